/* File: src/seef_idpage_mem.sv */
// identification page memory, registered read port
`timescale 1ns/100ps
`default_nettype none
module seef_idpage_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4,
    // identity bytes, values arbitrary
    parameter logic [7:0] ID0 = 8'h005a,
    parameter logic [7:0] ID1 = 8'h00a5,
    parameter logic [7:0] ID2 = 8'h003c
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    // storage, first three entries preloaded with identity bytes
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rd_q;

    // write port and reset preload
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= (i == 0) ? ID0 : (i == 1) ? ID1 :
                    (i == 2) ? ID2 : 8'h00ff;
            end
        end else if (ce_in && wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    // read data always from a register
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            rd_q <= 8'h0000;
        end else if (ce_in) begin
            rd_q <= mem_q[rd_addr_in];
        end
    end
    assign rd_data_out = rd_q;
endmodule : seef_idpage_mem
`default_nettype wire

/* File: src/seef_pkg.sv */
// package of constants shared by the serial eeprom front end
package seef_pkg;
    // select byte type identifiers, b7..b4
    localparam logic [3:0] TYPE_ARRAY = 4'h000a;
    localparam logic [3:0] TYPE_IDPAGE = 4'h000b;
    // select byte field positions
    localparam int SEL_TYPE_MSB = 7;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_HIADDR_MSB = 3;
    localparam int SEL_HIADDR_LSB = 1;
    localparam int SEL_RW_BIT = 0;
    // address byte fields for the identification page
    localparam int ADDR_LOCK_BIT = 7;
    localparam int IDP_LOC_MSB = 3;
    // lock instruction data byte bit
    localparam int LOCK_DATA_BIT = 1;
    // array geometry
    localparam int ARRAY_AW = 11;
    localparam int PAGE_AW = 4;
    localparam int IDP_DEPTH = 16;
    // reset values
    localparam logic [10:0] ADDR_RST = 11'h0000;
    // write cycle time in microseconds and clock period in ns
    localparam int WRITE_TIME_US = 4000;
    localparam int CLK_PERIOD_NS = 10;
    // write cycle time rounded up to whole clocks
    localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
endpackage : seef_pkg

/* File: src/seef_slave.sv */
// two-wire slave front end of a serial eeprom, write side
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - slave only, never drives clock
// - start is data fall, clock high
// - starts ignored while write cycle runs
// - stop is data rise, clock high
// - data bits sampled on clock rise
// - receiver pulls data low ninth pulse
// - select byte 1010, high addr, rw
// - type 1011 selects identification page
// - last select bit one read, zero write
// - ack match, else standby until start
// - eleven bit address from both bytes
// - id page bit7 zero, bits3..0 location
// - sixteen byte id page, three preloaded
// - write is select, address, then data
// - stop in tenth slot starts write
// - silent and released during write cycle
// - counter points past last written byte
// - protect high blocks write, nacks data
// - protect high still acks select, address
// - page write wraps within sixteen bytes
// - lock needs a7 set, data bit1
module seef_slave #(
    parameter int WRITE_CYCLES = seef_pkg::WRITE_CYCLES,
    parameter int PAGE_BYTES = 16
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic write_protect_input,
    output logic sda_out,
    output logic sda_oe_out,
    output logic busy_out,
    output logic [10:0] addr_out,
    output logic array_wr_out,
    output logic [10:0] array_wr_addr_out,
    output logic [7:0] array_wr_data_out,
    output logic lock_req_out
);
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    typedef enum {
        ST_IDLE, ST_SEL, ST_ADDR, ST_DATA, ST_ACK, ST_WAIT
    } seef_state_e;

    // three stage input synchronisers
    logic [2:0] scl_q, scl_d, sda_q, sda_d;
    // filtered bus levels, previous filtered levels
    logic scl_f_q, scl_f_d, sda_f_q, sda_f_d;
    // protect pin synchroniser and its filtered level
    logic [2:0] wp_q, wp_d;
    logic wp_f_q, wp_f_d;
    // protocol state
    seef_state_e state_q, state_d, after_ack_q, after_ack_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic ack_drive_q, ack_drive_d;
    logic idp_q, idp_d;
    logic lock_q, lock_d;
    logic slot10_q, slot10_d;
    logic pending_q, pending_d;
    logic [10:0] addr_q, addr_d;
    logic [10:0] last_q, last_d;
    // write cycle timer
    logic [CW-1:0] wcnt_q, wcnt_d;
    logic busy_q, busy_d;
    // outputs held in flops
    logic arr_wr_q, arr_wr_d;
    logic [10:0] arr_wa_q, arr_wa_d;
    logic [7:0] arr_wd_q, arr_wd_d;
    logic idp_wr_q, idp_wr_d;
    logic lock_req_q, lock_req_d;
    logic unused_rd;
    logic [7:0] idp_rd;

    // bus events from the agreeing second and third stages
    logic scl_rise, scl_fall, start_ev, stop_ev;
    always_comb begin
        scl_d = {scl_q[1:0], scl_in};
        sda_d = {sda_q[1:0], sda_in};
        scl_f_d = (scl_q[1] == scl_q[2]) ? scl_q[2] : scl_f_q;
        sda_f_d = (sda_q[1] == sda_q[2]) ? sda_q[2] : sda_f_q;
        wp_d = {wp_q[1:0], write_protect_input};
        wp_f_d = (wp_q[1] == wp_q[2]) ? wp_q[2] : wp_f_q;
    end
    assign scl_rise = scl_f_d & ~scl_f_q;
    assign scl_fall = ~scl_f_d & scl_f_q;
    assign start_ev = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
    assign stop_ev = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

    // synchroniser registers
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            wp_q <= 3'h0;
            wp_f_q <= 1'b0;
        end else if (ce_in) begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            scl_f_q <= scl_f_d;
            sda_f_q <= sda_f_d;
            wp_q <= wp_d;
            wp_f_q <= wp_f_d;
        end
    end

    // protocol next state
    always_comb begin
        state_d = state_q;
        after_ack_d = after_ack_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        ack_drive_d = ack_drive_q;
        idp_d = idp_q;
        lock_d = lock_q;
        slot10_d = slot10_q;
        pending_d = pending_q;
        addr_d = addr_q;
        last_d = last_q;
        wcnt_d = wcnt_q;
        busy_d = busy_q;
        arr_wr_d = 1'b0;
        arr_wa_d = arr_wa_q;
        arr_wd_d = arr_wd_q;
        idp_wr_d = 1'b0;
        lock_req_d = 1'b0;
        if (busy_q) begin
            state_d = ST_IDLE;
            ack_drive_d = 1'b0;
            if (wcnt_q == '0) begin
                busy_d = 1'b0;
                addr_d = idp_q ? {7'h0000,
                    last_q[3:0] + 4'h0001}
                    : last_q + 11'h0001;
            end else begin
                wcnt_d = wcnt_q - CW'(1);
            end
        end else if (stop_ev) begin
            state_d = ST_IDLE;
            ack_drive_d = 1'b0;
            if (slot10_q && pending_q) begin
                busy_d = 1'b1;
                wcnt_d = CW'(WRITE_CYCLES - 1);
            end
            pending_d = 1'b0;
            slot10_d = 1'b0;
        end else if (start_ev) begin
            // start opens a new select byte
            state_d = ST_SEL;
            bit_cnt_d = 4'h0000;
            ack_drive_d = 1'b0;
            slot10_d = 1'b0;
            pending_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    ack_drive_d = 1'b0;
                end
                ST_SEL, ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_f_q};
                        bit_cnt_d = bit_cnt_q + 4'h0001;
                    end
                    // tenth slot lasts until the next clock fall, so a
                    // stop's own clock rise does not close it
                    slot10_d = slot10_q & ~scl_fall;
                    // byte complete, decide ack on clock fall
                    if (scl_fall && bit_cnt_q == 4'h0008) begin
                        bit_cnt_d = 4'h0000;
                        state_d = ST_ACK;
                        after_ack_d = state_q;
                        ack_drive_d = 1'b0;
                        if (state_q == ST_SEL) begin
                            if (shift_q[7:4] == seef_pkg::TYPE_ARRAY ||
                                shift_q[7:4] == seef_pkg::TYPE_IDPAGE) begin
                                ack_drive_d = 1'b1;
                                idp_d = shift_q[7:4]
                                    == seef_pkg::TYPE_IDPAGE;
                                addr_d[10:8] = shift_q[3:1];
                                // reads belong to a neighbour
                                if (shift_q[0]) begin
                                    after_ack_d = ST_IDLE;
                                end
                            end else begin
                                state_d = ST_IDLE;
                            end
                        end else if (state_q == ST_ADDR) begin
                            ack_drive_d = 1'b1;
                            lock_d = idp_q & shift_q[7];
                            addr_d = idp_q ? {7'h0000, shift_q[3:0]}
                                : {addr_q[10:8], shift_q};
                        end else begin
                            ack_drive_d = ~wp_f_q;
                            if (!wp_f_q) begin
                                last_d = addr_q;
                                arr_wa_d = addr_q;
                                arr_wd_d = shift_q;
                                if (lock_q) begin
                                    lock_req_d =
                                        shift_q[seef_pkg::LOCK_DATA_BIT];
                                    pending_d = 1'b0;
                                end else begin
                                    pending_d = 1'b1;
                                    arr_wr_d = ~idp_q;
                                    idp_wr_d = idp_q;
                                end
                                addr_d = {addr_q[10:4],
                                    addr_q[3:0] + 4'h0001};
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        ack_drive_d = 1'b0;
                        state_d = (ack_drive_q && after_ack_q != ST_IDLE)
                            ? (after_ack_q == ST_SEL ? ST_ADDR : ST_DATA)
                            : ST_IDLE;
                        slot10_d = after_ack_q == ST_DATA;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // protocol registers
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            state_q <= ST_IDLE;
            after_ack_q <= ST_IDLE;
            bit_cnt_q <= 4'h0000;
            shift_q <= 8'h0000;
            ack_drive_q <= 1'b0;
            idp_q <= 1'b0;
            lock_q <= 1'b0;
            slot10_q <= 1'b0;
            pending_q <= 1'b0;
            addr_q <= seef_pkg::ADDR_RST;
            last_q <= seef_pkg::ADDR_RST;
            wcnt_q <= '0;
            busy_q <= 1'b0;
            arr_wr_q <= 1'b0;
            arr_wa_q <= 11'h0000;
            arr_wd_q <= 8'h0000;
            idp_wr_q <= 1'b0;
            lock_req_q <= 1'b0;
        end else if (ce_in) begin
            state_q <= state_d;
            after_ack_q <= after_ack_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            ack_drive_q <= ack_drive_d;
            idp_q <= idp_d;
            lock_q <= lock_d;
            slot10_q <= slot10_d;
            pending_q <= pending_d;
            addr_q <= addr_d;
            last_q <= last_d;
            wcnt_q <= wcnt_d;
            busy_q <= busy_d;
            arr_wr_q <= arr_wr_d;
            arr_wa_q <= arr_wa_d;
            arr_wd_q <= arr_wd_d;
            idp_wr_q <= idp_wr_d;
            lock_req_q <= lock_req_d;
        end
    end

    // id page storage beside the array
    seef_idpage_mem #(
        .DEPTH(seef_pkg::IDP_DEPTH),
        .AW(seef_pkg::PAGE_AW)
    ) u_idpage (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .wr_en_in(idp_wr_q),
        .wr_addr_in(arr_wa_q[3:0]),
        .wr_data_in(arr_wd_q),
        .rd_addr_in(addr_q[3:0]),
        .rd_data_out(idp_rd)
    );
    assign unused_rd = ^idp_rd;

    // only the data line is ever driven
    // output value fixed low, enable pulls
    assign sda_out = 1'b0;
    assign sda_oe_out = ack_drive_q;
    assign busy_out = busy_q;
    assign addr_out = addr_q;
    assign array_wr_out = arr_wr_q;
    assign array_wr_data_out = arr_wd_q;
    assign array_wr_addr_out = arr_wa_q;
    assign lock_req_out = lock_req_q;
endmodule : seef_slave
`default_nettype wire

/* File: test/seef_bus_master.sv */
// two-wire bus master model, clock paced by system clock edges
`timescale 1ns/100ps
`default_nettype none
module seef_bus_master (
    input wire logic clk_sys_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : wt
    task automatic start();
        wt(4);
        sda_oe_out = 1'b1;
        wt(4);
        scl_out = 1'b0;
    endtask : start
    task automatic stop();
        sda_oe_out = 1'b1;
        wt(2);
        scl_out = 1'b1;
        wt(4);
        sda_oe_out = 1'b0;
        wt(8);
    endtask : stop
    // one 80 ns bit slot with the clock high for 40 ns, line sampled just before the fall
    task automatic clk_bit(input logic b, output logic seen);
        wt(2);
        sda_oe_out = !b;
        wt(2);
        scl_out = 1'b1;
        wt(4);
        seen = sda_in;
        scl_out = 1'b0;
    endtask : clk_bit
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        // stretched low lets the synchronised ack settle
        wt(6);
        clk_bit(1'b1, s);
        ack = !s;
        wt(6);
    endtask : send_byte
endmodule : seef_bus_master
`default_nettype wire

/* File: test/seef_slave_assertions.sv */
// concurrent checks on the eeprom slave front end ports
`timescale 1ns/100ps
`default_nettype none
module seef_slave_assertions #(
    parameter int WRITE_CYCLES = 50
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic write_protect_input,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic busy_out,
    input wire logic [10:0] addr_out,
    input wire logic array_wr_out,
    input wire logic [10:0] array_wr_addr_out,
    input wire logic [7:0] array_wr_data_out,
    input wire logic lock_req_out
);
    int unsigned cnt_q; // cycles busy has been high so far
    int unsigned cnt_d;
    // count the busy run, cleared when busy drops
    always_comb begin
        cnt_d = busy_out ? cnt_q + 1 : 0;
    end
    always_ff @(posedge clk_sys_in) begin
        cnt_q <= rstn_in ? cnt_d : 0;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    oe_open_drain_a: assert property (sda_oe_out |-> !sda_out)
        else $error("data line driven high");
    busy_silent_a: assert property (busy_out |-> !sda_oe_out
        && !array_wr_out && !lock_req_out) else $error("busy not silent");
    busy_max_a: assert property (busy_out |-> cnt_q <= WRITE_CYCLES)
        else $error("write cycle too long");
    // one cycle of slack for the stop detector's alignment
    busy_len_a: assert property ($fell(busy_out) |->
        cnt_q >= WRITE_CYCLES - 1) else $error("write cycle too short");
    busy_at_stop_a: assert property ($rose(busy_out) |->
        scl_in && sda_in) else $error("write cycle without stop");
    ack_in_low_a: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("ack raised with clock high");
    ack_hold_a: assert property ($rose(scl_in) && sda_oe_out |=>
        sda_oe_out [*3]) else $error("ack not held over pulse");
    ack_drop_a: assert property ($fell(sda_oe_out) |-> !scl_in)
        else $error("ack dropped with clock high");
    wr_pulse_a: assert property (array_wr_out |=> !array_wr_out)
        else $error("write strobe longer than one cycle");
    wr_protect_a: assert property (array_wr_out |->
        !write_protect_input) else $error("write while protected");
    lock_pulse_a: assert property (lock_req_out |=> !lock_req_out)
        else $error("lock strobe longer than one cycle");
endmodule : seef_slave_assertions
`default_nettype wire

/* File: test/tb_seef_slave.sv */
// self-checking testbench of the eeprom slave front end
`timescale 1ns/100ps
`default_nettype none
module tb_seef_slave;
    localparam int WCYC = 400; // shortened, still longer than one poll
    logic clk_sys_in, rstn_in, wp, scl, m_oe, ack;
    logic sda_out, sda_oe_out, busy_out, array_wr_out, lock_req_out;
    logic [10:0] addr_out, wr_addr;
    logic [7:0] wr_data;
    wire logic sda_line; // wired-and with pull-up
    int num_errors = 0;
    int num_checks = 0;
    int locks = 0;
    logic [18:0] wr_q [$]; // captured array writes
    logic [7:0] pg [3] = '{8'h11, 8'h22, 8'h33};
    logic [10:0] wa [3] = '{11'h53E, 11'h53F, 11'h530};
    logic [7:0] ld [2] = '{8'hFD, 8'h02};
    assign sda_line = !(m_oe || (sda_oe_out && !sda_out));
    seef_slave #(.WRITE_CYCLES(WCYC)) dut_u (.clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in), .ce_in(1'b1), .scl_in(scl), .sda_in(sda_line),
        .write_protect_input(wp), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .busy_out(busy_out), .addr_out(addr_out),
        .array_wr_out(array_wr_out), .array_wr_addr_out(wr_addr),
        .array_wr_data_out(wr_data), .lock_req_out(lock_req_out));
    seef_bus_master u_m (.clk_sys_in(clk_sys_in), .sda_in(sda_line),
        .scl_out(scl), .sda_oe_out(m_oe));
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // log array strobes and lock strobes
    always @(posedge clk_sys_in) begin
        if (array_wr_out === 1'b1) wr_q.push_back({wr_addr, wr_data});
        if (lock_req_out === 1'b1) locks++;
    end
    task automatic chk(input string w, input logic [18:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
        end
    endtask : chk
    // send a byte; an unknown expectation skips the ack compare
    task automatic sb(input logic [7:0] d, input logic exp, input string w);
        u_m.send_byte(d, ack);
        if (exp !== 1'bx) chk(w, 19'(ack), 19'(exp));
    endtask : sb
    task automatic wait_idle();
        for (int i = 0; i < 2000 && busy_out !== 1'b0; i++)
            @(negedge clk_sys_in);
        chk("idle", 19'(busy_out), 19'h0);
    endtask : wait_idle
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (30000) @(posedge clk_sys_in);
        num_errors++;
        $display("watchdog expired");
        complete_run();
    end
    initial begin
        rstn_in = 1'b0;
        wp = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        // page write rolling over the page end, then a poll while busy
        u_m.start();
        sb(8'hAA, 1'b1, "sel");
        sb(8'h3E, 1'b1, "adr");
        foreach (pg[i]) sb(pg[i], 1'b1, "dat");
        u_m.stop();
        chk("busy", 19'(busy_out), 19'h1);
        u_m.start();
        sb(8'hAA, 1'b0, "poll");
        u_m.stop();
        wait_idle();
        chk("addr", 19'(addr_out), 19'h531);
        chk("nwr", 19'(wr_q.size()), 19'h3);
        foreach (pg[i]) chk("wr", wr_q[i], {wa[i], pg[i]});
        // protected write: header acked, data refused
        wp = 1'b1;
        u_m.start();
        sb(8'hAA, 1'b1, "wp sel");
        sb(8'h10, 1'b1, "wp adr");
        sb(8'h55, 1'b0, "wp dat");
        u_m.stop();
        chk("wp busy", 19'(busy_out), 19'h0);
        wp = 1'b0;
        // foreign type leaves the device in standby
        u_m.start();
        sb(8'h90, 1'b0, "bad sel");
        sb(8'h10, 1'b0, "standby");
        u_m.stop();
        u_m.start();
        sb(8'hA1, 1'b1, "rd sel");
        u_m.stop();
        // stop after the address slot starts no write cycle
        u_m.start();
        sb(8'hAA, 1'b1, "sel2");
        sb(8'h10, 1'b1, "adr2");
        u_m.stop();
        chk("no cycle", 19'(busy_out), 19'h0);
        // id page write with the ignored bits set
        u_m.start();
        sb(8'hBE, 1'b1, "id sel");
        sb(8'h75, 1'b1, "id adr");
        sb(8'h66, 1'b1, "id dat");
        u_m.stop();
        wait_idle();
        chk("id nwr", 19'(wr_q.size()), 19'h3);
        chk("id addr", 19'(addr_out), 19'h6);
        // lock only with data bit one set
        foreach (ld[i]) begin
            u_m.start();
            sb(8'hBE, 1'b1, "lk sel");
            sb(8'h80, 1'b1, "lk adr");
            sb(ld[i], 1'b1, "lk dat");
            u_m.stop();
            wait_idle();
            chk("locks", 19'(locks), 19'(i));
        end
        complete_run();
    end
endmodule : tb_seef_slave
bind seef_slave seef_slave_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .scl_in(scl_in), .sda_in(sda_in),
    .write_protect_input(write_protect_input), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .busy_out(busy_out), .addr_out(addr_out),
    .array_wr_out(array_wr_out), .array_wr_addr_out(array_wr_addr_out),
    .array_wr_data_out(array_wr_data_out), .lock_req_out(lock_req_out));
`default_nettype wire
